// [logic/pief_top.sv]
`timescale 1ns/10ps
module pief_top
  import pief_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic AVS_RESPONSE_ERR,
  input wire pief_evt_a_t EVT_A,
  input wire pief_evt_b_t EVT_B,
  output logic PERIPH_IRQ
);

  logic [7:0] ena_ff;
  logic [7:0] enb_ff;
  logic [7:0] flga_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] evt_b_ff;
  pief_bus_st_t st_ff;
  logic [7:0] evt_a_vec;
  logic [7:0] evt_b_vec;
  logic wr_go;
  logic rd_go;
  logic lane0;
  logic [7:0] nxt_flga;
  logic [7:0] rd_mux;
  logic irq_a_any;
  logic irq_b_any;
  logic nxt_irq;
  logic [31:0] nxt_rdata;

  // Address decode used by both read mux and write strobes
  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    hit = (a == r);
  endfunction : hit

  function automatic logic mapped(input logic [4:0] a);
    mapped = hit(a, PIEF_ADDR_ENA) | hit(a, PIEF_ADDR_ENB) |
             hit(a, PIEF_ADDR_FLGA) | hit(a, PIEF_ADDR_CTRL) |
             hit(a, PIEF_ADDR_STAT);
  endfunction : mapped

  // Event pulses mapped onto the register bit layout
  always_comb begin
    evt_a_vec = 8'h00;
    evt_a_vec[PIEF_B_ADC] = EVT_A.adc_done;
    evt_a_vec[PIEF_B_BCL] = EVT_A.bus_collision;
    evt_a_vec[PIEF_B_SSP] = EVT_A.serial_port;
    evt_a_vec[PIEF_B_TMB] = EVT_A.timer_b_match;
    evt_a_vec[PIEF_B_TMA] = EVT_A.timer_a_rollover;
    evt_b_vec = 8'h00;
    evt_b_vec[PIEF_B_UV] = EVT_B.out_undervolt;
    evt_b_vec[PIEF_B_OC] = EVT_B.out_overcurrent;
    evt_b_vec[PIEF_B_OV] = EVT_B.out_overvolt;
    evt_b_vec[PIEF_B_VIN] = EVT_B.input_undervoltage_lockout;
  end

  // Bus handshake: one wait cycle, request taken in ACK state
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      st_ff <= PIEF_IDLE;
    end else begin
      case (st_ff)
        PIEF_IDLE: begin
          if (AVS_READ | AVS_WRITE) begin
            st_ff <= PIEF_ACK;
          end
        end
        PIEF_ACK: begin
          st_ff <= PIEF_IDLE;
        end
        default: begin
          st_ff <= PIEF_IDLE;
        end
      endcase
    end
  end

  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & (st_ff != PIEF_ACK);
  assign wr_go = AVS_WRITE & (st_ff == PIEF_ACK);
  assign rd_go = AVS_READ & (st_ff == PIEF_ACK);
  assign lane0 = AVS_BYTEENABLE[0];

  // Enable registers, unimplemented bits never stored
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      ena_ff <= PIEF_RST_ENA;
      enb_ff <= PIEF_RST_ENB;
      ctrl_ff <= PIEF_RST_CTRL;
    end else if (wr_go && lane0) begin
      if (hit(AVS_ADDRESS, PIEF_ADDR_ENA)) begin
        ena_ff <= AVS_WRITEDATA[7:0] & PIEF_MASK_A;
      end
      if (hit(AVS_ADDRESS, PIEF_ADDR_ENB)) begin
        enb_ff <= AVS_WRITEDATA[7:0] & PIEF_MASK_B;
      end
      if (hit(AVS_ADDRESS, PIEF_ADDR_CTRL)) begin
        ctrl_ff <= AVS_WRITEDATA[7:0] & PIEF_MASK_CTRL;
      end
    end
  end

  // Flags: software writes value, a same-cycle event wins
  always_comb begin
    nxt_flga = flga_ff;
    if (wr_go && lane0 && hit(AVS_ADDRESS, PIEF_ADDR_FLGA)) begin
      nxt_flga = AVS_WRITEDATA[7:0];
    end
    nxt_flga = (nxt_flga | evt_a_vec) & PIEF_MASK_A;
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      flga_ff <= PIEF_RST_FLGA;
    end else begin
      flga_ff <= nxt_flga;
    end
  end

  // Second-bank events latched sticky until written clear
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      evt_b_ff <= 8'h00;
    end else if (wr_go && lane0 && hit(AVS_ADDRESS, PIEF_ADDR_STAT)) begin
      evt_b_ff <= ((evt_b_ff & AVS_WRITEDATA[7:0]) | evt_b_vec) & PIEF_MASK_B;
    end else begin
      evt_b_ff <= (evt_b_ff | evt_b_vec) & PIEF_MASK_B;
    end
  end

  // Interrupt request tree
  assign irq_a_any = |(flga_ff & ena_ff);
  assign irq_b_any = |(evt_b_ff & enb_ff);
  assign nxt_irq = (irq_a_any | irq_b_any) & ctrl_ff[PIEF_B_PERIPH_IRQ_MASTER_EN] &
                   ctrl_ff[PIEF_B_GIE];

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      PERIPH_IRQ <= 1'b0;
    end else begin
      PERIPH_IRQ <= nxt_irq;
    end
  end

  // Read data, unimplemented bits read zero
  always_comb begin
    rd_mux = 8'h00;
    if (hit(AVS_ADDRESS, PIEF_ADDR_ENA)) begin
      rd_mux = ena_ff & PIEF_MASK_A;
    end else if (hit(AVS_ADDRESS, PIEF_ADDR_ENB)) begin
      rd_mux = enb_ff & PIEF_MASK_B;
    end else if (hit(AVS_ADDRESS, PIEF_ADDR_FLGA)) begin
      rd_mux = flga_ff & PIEF_MASK_A;
    end else if (hit(AVS_ADDRESS, PIEF_ADDR_CTRL)) begin
      rd_mux = ctrl_ff;
    end else if (hit(AVS_ADDRESS, PIEF_ADDR_STAT)) begin
      rd_mux = evt_b_ff;
    end
    nxt_rdata = {24'h000000, rd_mux};
  end

  // Read data registered while the request waits
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      AVS_READDATA <= 32'h00000000;
    end else if (AVS_READ && st_ff == PIEF_IDLE) begin
      AVS_READDATA <= nxt_rdata;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      AVS_RESPONSE_ERR <= 1'b0;
    end else if (AVS_READ | AVS_WRITE) begin
      AVS_RESPONSE_ERR <= !mapped(AVS_ADDRESS);
    end
  end

  // Checks
  AST_IRQ_GATED: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    !(ctrl_ff[PIEF_B_GIE] && ctrl_ff[PIEF_B_PERIPH_IRQ_MASTER_EN])
    |=> !PERIPH_IRQ)
    else $error("Irq raised while gated off");
  AST_IRQ_CAUSE: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    PERIPH_IRQ
    |-> $past(irq_a_any | irq_b_any))
    else $error("Irq without enabled flag");
  AST_IRQ_NONE: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    ((flga_ff & ena_ff) == 8'h00 && (evt_b_ff & enb_ff) == 8'h00)
    |=> !PERIPH_IRQ)
    else $error("Irq with no enabled source");
  AST_A_MASKED: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (ena_ff == 8'h00 && enb_ff == 8'h00)
    |=> !PERIPH_IRQ)
    else $error("Irq with all enables clear");
  AST_ADC_EN: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (flga_ff[PIEF_B_ADC] && ena_ff[PIEF_B_ADC] && ctrl_ff == PIEF_MASK_CTRL)
    |=> PERIPH_IRQ)
    else $error("Adc interrupt not delivered");
  AST_BCL_EN: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (flga_ff[PIEF_B_BCL] && ena_ff[PIEF_B_BCL] && ctrl_ff == PIEF_MASK_CTRL)
    |=> PERIPH_IRQ)
    else $error("Bus collision interrupt not delivered");
  AST_SSP_EN: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (flga_ff[PIEF_B_SSP] && ena_ff[PIEF_B_SSP] && ctrl_ff == PIEF_MASK_CTRL)
    |=> PERIPH_IRQ)
    else $error("Serial port interrupt not delivered");
  AST_TMB_EN: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (flga_ff[PIEF_B_TMB] && ena_ff[PIEF_B_TMB] && ctrl_ff == PIEF_MASK_CTRL)
    |=> PERIPH_IRQ)
    else $error("Timer b interrupt not delivered");
  AST_TMA_EN: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (flga_ff[PIEF_B_TMA] && ena_ff[PIEF_B_TMA] && ctrl_ff == PIEF_MASK_CTRL)
    |=> PERIPH_IRQ)
    else $error("Timer a interrupt not delivered");
  AST_UV_EN: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (evt_b_ff[PIEF_B_UV] && enb_ff[PIEF_B_UV] && ctrl_ff == PIEF_MASK_CTRL)
    |=> PERIPH_IRQ)
    else $error("Undervolt interrupt not delivered");
  AST_OC_EN: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (evt_b_ff[PIEF_B_OC] && enb_ff[PIEF_B_OC] && ctrl_ff == PIEF_MASK_CTRL)
    |=> PERIPH_IRQ)
    else $error("Overcurrent interrupt not delivered");
  AST_OV_EN: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (evt_b_ff[PIEF_B_OV] && enb_ff[PIEF_B_OV] && ctrl_ff == PIEF_MASK_CTRL)
    |=> PERIPH_IRQ)
    else $error("Overvolt interrupt not delivered");
  AST_VIN_EN: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (evt_b_ff[PIEF_B_VIN] && enb_ff[PIEF_B_VIN] && ctrl_ff == PIEF_MASK_CTRL)
    |=> PERIPH_IRQ)
    else $error("Input undervoltage_lockout interrupt not delivered");
  AST_FLAG_SET: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    EVT_A.timer_b_match
    |=> flga_ff[PIEF_B_TMB])
    else $error("Timer b flag not set");
  AST_TMA_FLAG: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    EVT_A.timer_a_rollover
    |=> flga_ff[PIEF_B_TMA])
    else $error("Timer a flag not set");
  AST_ADC_FLAG: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    EVT_A.adc_done
    |=> flga_ff[PIEF_B_ADC])
    else $error("Adc flag not set");
  AST_BCL_FLAG: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    EVT_A.bus_collision
    |=> flga_ff[PIEF_B_BCL])
    else $error("Bus collision flag not set");
  AST_SSP_FLAG: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    EVT_A.serial_port
    |=> flga_ff[PIEF_B_SSP])
    else $error("Serial port flag not set");
  AST_B_STICKY: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (evt_b_vec != 8'h00)
    |=> ((evt_b_ff & $past(evt_b_vec)) == $past(evt_b_vec)))
    else $error("Bank b event not latched");
  AST_FLAG_HOLD: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (flga_ff[PIEF_B_TMA] && !wr_go)
    |=> flga_ff[PIEF_B_TMA])
    else $error("Timer a flag dropped");
  AST_TMB_HOLD: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (flga_ff[PIEF_B_TMB] && !wr_go)
    |=> flga_ff[PIEF_B_TMB])
    else $error("Timer b flag dropped");
  AST_TMB_CLR: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (wr_go && lane0 && hit(AVS_ADDRESS, PIEF_ADDR_FLGA) &&
     !AVS_WRITEDATA[PIEF_B_TMB] && !EVT_A.timer_b_match)
    |=> !flga_ff[PIEF_B_TMB])
    else $error("Timer b flag not cleared");
  AST_TMA_CLR: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (wr_go && lane0 && hit(AVS_ADDRESS, PIEF_ADDR_FLGA) &&
     !AVS_WRITEDATA[PIEF_B_TMA] && !EVT_A.timer_a_rollover)
    |=> !flga_ff[PIEF_B_TMA])
    else $error("Timer a flag not cleared");
  AST_ADC_ZERO: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (!flga_ff[PIEF_B_ADC] && !EVT_A.adc_done && !wr_go)
    |=> !flga_ff[PIEF_B_ADC])
    else $error("Adc flag set with no conversion");
  AST_UNIMP_A: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (flga_ff & ~PIEF_MASK_A) == 8'h00 &&
    (ena_ff & ~PIEF_MASK_A) == 8'h00)
    else $error("Unimplemented bit set");
  AST_UNIMP_B: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (enb_ff & ~PIEF_MASK_B) == 8'h00 &&
    (evt_b_ff & ~PIEF_MASK_B) == 8'h00)
    else $error("Unimplemented bank b bit set");
  AST_RD_UNIMP: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (rd_go && (hit(AVS_ADDRESS, PIEF_ADDR_ENA) ||
     hit(AVS_ADDRESS, PIEF_ADDR_FLGA)))
    |-> (AVS_READDATA & ~{24'h000000, PIEF_MASK_A}) == 32'h00000000)
    else $error("Unimplemented bit read as one");
  AST_RESET: assert property (
    @(posedge CLOCK)
    !RSTN
    |=> (ena_ff == 8'h00 && enb_ff == 8'h00 && flga_ff == 8'h00))
    else $error("Reset did not clear registers");
  AST_RESET_IRQ: assert property (
    @(posedge CLOCK)
    !RSTN
    |=> (!PERIPH_IRQ && ctrl_ff == 8'h00 && evt_b_ff == 8'h00))
    else $error("Reset did not clear request");

endmodule : pief_top

// [logic/pief_pkg.sv]
package pief_pkg;
  // Register byte addresses on the Avalon-MM bus (word aligned)
  localparam logic [4:0] PIEF_ADDR_ENA = 5'h00;
  localparam logic [4:0] PIEF_ADDR_ENB = 5'h04;
  localparam logic [4:0] PIEF_ADDR_FLGA = 5'h08;
  localparam logic [4:0] PIEF_ADDR_CTRL = 5'h0c;
  localparam logic [4:0] PIEF_ADDR_STAT = 5'h10;
  // Field positions, enable and flag A share a layout
  localparam int PIEF_B_ADC = 6;
  localparam int PIEF_B_BCL = 5;
  localparam int PIEF_B_SSP = 4;
  localparam int PIEF_B_TMB = 1;
  localparam int PIEF_B_TMA = 0;
  localparam int PIEF_B_UV = 7;
  localparam int PIEF_B_OC = 5;
  localparam int PIEF_B_OV = 4;
  localparam int PIEF_B_VIN = 1;
  localparam int PIEF_B_GIE = 7;
  localparam int PIEF_B_PERIPH_IRQ_MASTER_EN = 6;
  // Implemented bit masks
  localparam logic [7:0] PIEF_MASK_A = 8'h73;
  localparam logic [7:0] PIEF_MASK_B = 8'hb2;
  localparam logic [7:0] PIEF_MASK_CTRL = 8'hc0;
  // Reset values
  localparam logic [7:0] PIEF_RST_ENA = 8'h00;
  localparam logic [7:0] PIEF_RST_ENB = 8'h00;
  localparam logic [7:0] PIEF_RST_FLGA = 8'h00;
  localparam logic [7:0] PIEF_RST_CTRL = 8'h00;

  typedef struct packed {
    logic adc_done;
    logic bus_collision;
    logic serial_port;
    logic timer_b_match;
    logic timer_a_rollover;
  } pief_evt_a_t;

  typedef struct packed {
    logic out_undervolt;
    logic out_overcurrent;
    logic out_overvolt;
    logic input_undervoltage_lockout;
  } pief_evt_b_t;

  typedef enum logic [1:0] {
    PIEF_IDLE = 2'b00,
    PIEF_ACK = 2'b01
  } pief_bus_st_t;
endpackage : pief_pkg

// [dv/pief_top_bench.sv]
`timescale 1ns/10ps
module pief_top_bench;
  import pief_pkg::*;
  logic CLOCK;
  logic RSTN;
  logic [4:0] AVS_ADDRESS;
  logic AVS_READ;
  logic AVS_WRITE;
  logic [31:0] AVS_WRITEDATA;
  logic [3:0] AVS_BYTEENABLE;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic AVS_RESPONSE_ERR;
  pief_evt_a_t EVT_A;
  pief_evt_b_t EVT_B;
  logic PERIPH_IRQ;
  int bad_count;
  int n_checks;
  logic [31:0] exp_q[$];
  logic err_q[$];
  logic [31:0] seed;
  int pos_a[5] = '{6, 5, 4, 1, 0};
  int pos_b[4] = '{7, 5, 4, 1};

  pief_top dut_u (.CLOCK(CLOCK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .AVS_RESPONSE_ERR(AVS_RESPONSE_ERR), .EVT_A(EVT_A), .EVT_B(EVT_B),
    .PERIPH_IRQ(PERIPH_IRQ));

  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d,
                     input logic [3:0] be);
    AVS_ADDRESS <= a;
    AVS_READ <= ~w;
    AVS_WRITE <= w;
    AVS_WRITEDATA <= {24'h000000, d};
    AVS_BYTEENABLE <= be;
    do begin
      @(posedge CLOCK);
    end while (AVS_WAITREQUEST !== 1'b0);
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    @(posedge CLOCK);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, 4'hf);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    err_q.push_back(!(a inside {PIEF_ADDR_ENA, PIEF_ADDR_ENB,
                      PIEF_ADDR_FLGA, PIEF_ADDR_CTRL, PIEF_ADDR_STAT}));
    bus(a, 1'b0, 8'h00, 4'hf);
  endtask : rd

  task automatic pulse(input logic [4:0] a, input logic [3:0] b);
    EVT_A <= a;
    EVT_B <= b;
    @(posedge CLOCK);
    EVT_A <= 5'h00;
    EVT_B <= 4'h0;
    @(posedge CLOCK);
  endtask : pulse

  task automatic irq_chk(input logic e);
    @(posedge CLOCK);
    chk({31'h0, PERIPH_IRQ}, {31'h0, e});
  endtask : irq_chk

  // Read data taken at the edge that ends the access
  always @(posedge CLOCK) begin
    if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0 &&
        exp_q.size() > 0) begin
      chk(AVS_READDATA, exp_q.pop_front());
      chk({31'h0, AVS_RESPONSE_ERR}, {31'h0, err_q.pop_front()});
    end
  end

  initial begin
    repeat (6000) @(posedge CLOCK);
    bad_count++;
    close_out();
  end

  initial begin
    RSTN = 1'b0;
    AVS_ADDRESS = 5'h00;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h00000000;
    AVS_BYTEENABLE = 4'hf;
    EVT_A = 5'h00;
    EVT_B = 4'h0;
    bad_count = 0;
    n_checks = 0;
    seed = 32'h5458e1a0;
    repeat (8) @(posedge CLOCK);
    RSTN <= 1'b1;
    @(posedge CLOCK);
    rd(PIEF_ADDR_ENA, 8'h00);
    rd(PIEF_ADDR_ENB, 8'h00);
    rd(PIEF_ADDR_FLGA, 8'h00);
    rd(PIEF_ADDR_CTRL, 8'h00);
    rd(5'h06, 8'h00);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr_next(seed);
      wr(PIEF_ADDR_ENA, seed[7:0]);
      rd(PIEF_ADDR_ENA, seed[7:0] & 8'h73);
      wr(PIEF_ADDR_ENB, seed[15:8]);
      rd(PIEF_ADDR_ENB, seed[15:8] & 8'hb2);
      wr(PIEF_ADDR_CTRL, seed[23:16]);
      rd(PIEF_ADDR_CTRL, seed[23:16] & 8'hc0);
    end
    bus(PIEF_ADDR_ENA, 1'b1, 8'h00, 4'h0);
    rd(PIEF_ADDR_ENA, seed[7:0] & 8'h73);
    wr(PIEF_ADDR_ENA, 8'h00);
    wr(PIEF_ADDR_ENB, 8'h00);
    wr(PIEF_ADDR_CTRL, 8'h00);
    pulse(5'h1f, 4'hf);
    irq_chk(1'b0);
    rd(PIEF_ADDR_FLGA, 8'h73);
    wr(PIEF_ADDR_FLGA, 8'h00);
    rd(PIEF_ADDR_FLGA, 8'h00);
    rd(PIEF_ADDR_STAT, 8'hb2);
    wr(PIEF_ADDR_STAT, 8'h00);
    rd(PIEF_ADDR_STAT, 8'h00);
    wr(PIEF_ADDR_CTRL, 8'hc0);
    for (int i = 0; i < 5; i++) begin
      wr(PIEF_ADDR_ENA, 8'h01 << pos_a[i]);
      irq_chk(1'b0);
      pulse(5'h01 << (4 - i), 4'h0);
      irq_chk(1'b1);
      rd(PIEF_ADDR_FLGA, 8'h01 << pos_a[i]);
      wr(PIEF_ADDR_CTRL, 8'h80);
      irq_chk(1'b0);
      wr(PIEF_ADDR_CTRL, 8'h40);
      irq_chk(1'b0);
      wr(PIEF_ADDR_CTRL, 8'hc0);
      irq_chk(1'b1);
      wr(PIEF_ADDR_FLGA, 8'h00);
      irq_chk(1'b0);
      wr(PIEF_ADDR_ENA, 8'h00);
    end
    for (int k = 0; k < 4; k++) begin
      wr(PIEF_ADDR_ENB, 8'h01 << pos_b[k]);
      irq_chk(1'b0);
      pulse(5'h00, 4'h1 << (3 - k));
      irq_chk(1'b1);
      rd(PIEF_ADDR_STAT, 8'h01 << pos_b[k]);
      wr(PIEF_ADDR_ENB, 8'h00);
      irq_chk(1'b0);
      wr(PIEF_ADDR_STAT, 8'h00);
    end
    close_out();
  end
endmodule : pief_top_bench
